// ### hdl/agr_latch.sv
// One latched status flag, high or low latching, reloaded on read.
// Assumes rd_i is a one-cycle pulse at the edge that takes the read.
`timescale 1ns/10ps
`default_nettype none

module agr_latch import agr_pkg::*; #(
	parameter bit LATCH_HIGH = 1'b1
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset
	input wire logic ce_i, // Clock enable
	input wire logic live_i, // Live condition
	input wire logic rd_i, // Read of the flag
	output logic q_o // Latched flag
);

	logic next_q;

	// A read reloads from live, so an event in the read cycle survives
	assign next_q = rd_i ? live_i : (LATCH_HIGH ? (q_o | live_i) : (q_o & live_i));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= 1'b0;
		end else if (ce_i) begin
			q_o <= next_q;
		end
	end

endmodule

`default_nettype wire

// ### hdl/agr_params.svh
// Constants of the autonegotiation and gigabit register bank.
// Assumes a 32-bit Wishbone bus; each register is one word at four times its index.
// Notes on behaviour
// RQ1: Partner base bits 15-13 read-only, reset zero
// RQ2: Partner base bits 11,10 show pause abilities
// RQ3: Partner base bits 9-5 show speed abilities
// RQ4: Parallel detection fault latches high until read
// RQ5: Page received flag latches low until read
// RQ6: Bit 3 partner next page, bit 2 local
// RQ7: Bit 0 partner can negotiate; 15-5 zero
// RQ8: Software sets more-pages, message bit, code field
// RQ9: Software sets comply bit per partner request
// RQ10: Toggle reads inverse of last sent toggle
// RQ11: Receive register mirrors received next page
// RQ12: Test field picks normal or four tests
// RQ13: Forced role applies only with manual enable
// RQ14: Gigabit ability and port type reset one
// RQ15: Software disables media sense before tests
// RQ16: Role configuration fault latches high until read
// RQ17: Resolved role kept from initial resolution
// RQ18: Bits 13,12 show local, remote receiver state
// RQ19: Bits 11,10 partner gigabit, 9-8 zero
// RQ20: Function field selects address or data modes
// RQ21: Software writes target device address bits 4-0
// RQ22: Window holds address or data per function
// RQ23: Latched flags and idle count reload on read
`ifndef AGR_PARAMS_SVH
`define AGR_PARAMS_SVH

`define AGR_IDX_PBA 6'h05
`define AGR_IDX_EXP 6'h06
`define AGR_IDX_NPT 6'h07
`define AGR_IDX_NPR 6'h08
`define AGR_IDX_GCTL 6'h09
`define AGR_IDX_GSTS 6'h0A
`define AGR_IDX_IAC 6'h0D
`define AGR_IDX_WIN 6'h0E

`define AGR_NPT_RST 16'h2001
`define AGR_GCTL_RST 16'h0700
`define AGR_IAC_RST 16'h0000
`define AGR_GSTS_ROLE_RST 1'h1

`define AGR_NPT_TOGGLE 11
`define AGR_NPT_RSVD 14
`define AGR_BASE_NP 15
`define AGR_GCTL_TEST_HI 15
`define AGR_GCTL_TEST_LO 13
`define AGR_GCTL_MANUAL 12
`define AGR_GCTL_MASTER 11
`define AGR_GCTL_PORT 10
`define AGR_GCTL_FDX 9
`define AGR_GCTL_HDX 8
`define AGR_IAC_FN_HI 15
`define AGR_IAC_FN_LO 14
`define AGR_IAC_DEV_HI 4

`endif

// ### hdl/agr_pkg.sv
// Types of the autonegotiation and gigabit register bank.
// Used by the bank and its latch cells.
package agr_pkg;

	typedef enum logic [2:0] {
		AGR_TM_NORMAL,
		AGR_TM_WAVEFORM,
		AGR_TM_JITTER_MASTER,
		AGR_TM_JITTER_SLAVE,
		AGR_TM_DISTORTION
	} agr_tm_e;

	typedef enum logic [1:0] {
		AGR_FN_ADDRESS,
		AGR_FN_DATA,
		AGR_FN_DATA_INC_RW,
		AGR_FN_DATA_INC_W
	} agr_fn_e;

	typedef logic [15:0] agr_word_t;

endpackage

// ### hdl/agr_regs.sv
// Autonegotiation, gigabit control/status and indirect access register bank.
// Assumes a classic Wishbone master and a PHY core giving pulses and levels
// synchronous to clk_i; mmd_rdata_i must follow mmd_addr_o in the same cycle.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "agr_params.svh"

module agr_regs import agr_pkg::*; (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic ce_i, // Clock enable, freezes state when low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic rx_page_i, // Page received pulse
	input wire logic rx_next_page_i, // Received page is a next page
	input wire logic [15:0] rx_word_i, // Received page word
	input wire logic page_rcvd_i, // Live page-received condition
	input wire logic pd_fault_i, // Parallel detection fault
	input wire logic lp_an_able_i, // Partner can autonegotiate
	input wire logic tx_sent_i, // Link codeword sent pulse
	input wire logic tx_lcw_toggle_i, // Toggle of the codeword sent
	input wire logic ms_fault_i, // Role configuration fault
	input wire logic ms_resolve_i, // Initial role resolution pulse
	input wire logic ms_resolved_master_i, // Resolved as master
	input wire logic local_rx_ok_i, // Local receiver normal
	input wire logic remote_rx_ok_i, // Remote receiver OK
	input wire logic lp_1000_fdx_i, // Partner gigabit full duplex
	input wire logic lp_1000_hdx_i, // Partner gigabit half duplex
	input wire logic idle_err_i, // Idle error pulse
	input wire logic [15:0] mmd_rdata_i, // Indirect read data
	output logic [15:0] np_tx_word_o, // Next page to transmit
	output agr_tm_e test_mode_o, // Transmitter test mode
	output logic ms_force_o, // Manual role enabled
	output logic ms_master_o, // Forced master role
	output logic adv_1000_fdx_o, // Advertise gigabit full duplex
	output logic adv_1000_hdx_o, // Advertise gigabit half duplex
	output logic port_single_o, // Single-port type
	output logic [4:0] mmd_dev_o, // Target device address
	output logic [15:0] mmd_addr_o, // Indirect register address
	output logic [15:0] mmd_wdata_o, // Indirect write data
	output logic mmd_wr_o, // Indirect write pulse
	output logic mmd_rd_o // Indirect read pulse
);

	// Byte-lane merge for the 16-bit registers
	function automatic agr_word_t lane_merge(agr_word_t old, logic [31:0] dat, logic [3:0] sel);
		lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	agr_word_t pba;
	agr_word_t npr;
	agr_word_t npt;
	agr_word_t gctl;
	agr_word_t iac;
	agr_word_t win_addr;
	logic toggle;
	logic role_master;
	logic [7:0] idle_cnt;
	logic lp_np_able;
	logic flag_pdf;
	logic flag_prx;
	logic flag_msf;

	wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic take = req & ce_i;
	wire logic [5:0] idx = wb_adr_i[7:2];
	wire logic wr = take & wb_we_i;
	wire logic rd = take & ~wb_we_i;
	wire logic hit_pba = idx == `AGR_IDX_PBA;
	wire logic hit_exp = idx == `AGR_IDX_EXP;
	wire logic hit_npt = idx == `AGR_IDX_NPT;
	wire logic hit_npr = idx == `AGR_IDX_NPR;
	wire logic hit_gctl = idx == `AGR_IDX_GCTL;
	wire logic hit_gsts = idx == `AGR_IDX_GSTS;
	wire logic hit_iac = idx == `AGR_IDX_IAC;
	wire logic hit_win = idx == `AGR_IDX_WIN;
	wire agr_fn_e fn = agr_fn_e'(iac[`AGR_IAC_FN_HI:`AGR_IAC_FN_LO]);
	wire logic fn_addr = fn == AGR_FN_ADDRESS;
	wire logic rd_exp = rd & hit_exp;
	wire logic rd_gsts = rd & hit_gsts;
	wire logic win_wr = wr & hit_win;
	wire logic win_rd = rd & hit_win;
	// Post-increment only in data modes, and on reads only for mode 10
	wire logic inc_after_wr = win_wr & (fn == AGR_FN_DATA_INC_RW || fn == AGR_FN_DATA_INC_W);
	wire logic inc_after_rd = win_rd & (fn == AGR_FN_DATA_INC_RW);

	// Expansion word: upper bits wired to zero
	wire agr_word_t exp_word = {11'h000, flag_pdf, lp_np_able, 1'b1, flag_prx, lp_an_able_i}; // RQ6 RQ7
	wire agr_word_t npt_word = {npt[15], 1'b0, npt[13:12], toggle, npt[10:0]}; // RQ10
	wire agr_word_t gsts_word = {flag_msf, role_master, local_rx_ok_i, remote_rx_ok_i,
		lp_1000_fdx_i, lp_1000_hdx_i, 2'h0, idle_cnt}; // RQ16 RQ18 RQ19
	wire agr_word_t win_word = fn_addr ? win_addr : mmd_rdata_i; // RQ22

	agr_word_t rdata;
	always_comb begin
		rdata = 16'h0000;
		unique case (1'b1)
			hit_pba: rdata = pba; // RQ1 RQ2 RQ3
			hit_exp: rdata = exp_word;
			hit_npt: rdata = npt_word;
			hit_npr: rdata = npr; // RQ11
			hit_gctl: rdata = gctl;
			hit_gsts: rdata = gsts_word;
			hit_iac: rdata = iac;
			hit_win: rdata = win_word;
			default: rdata = 16'h0000;
		endcase
	end

	wire agr_tm_e next_test_mode = (gctl[`AGR_GCTL_TEST_HI:`AGR_GCTL_TEST_LO] > 3'h4) ?
		AGR_TM_NORMAL : agr_tm_e'(gctl[`AGR_GCTL_TEST_HI:`AGR_GCTL_TEST_LO]); // RQ12

	// Wishbone slave: answer one cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? {16'h0000, rdata} : 32'h0000_0000;
		end
	end

	// Received pages land in base or next-page registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pba <= 16'h0000;
			npr <= 16'h0000;
			lp_np_able <= 1'b0;
		end else if (ce_i && rx_page_i) begin
			if (rx_next_page_i) begin
				npr <= rx_word_i; // RQ11
			end else begin
				pba <= rx_word_i; // RQ1 RQ2 RQ3
				lp_np_able <= rx_word_i[`AGR_BASE_NP]; // RQ6
			end
		end
	end

	// Software-owned next page fields; reserved bit held at zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			npt <= `AGR_NPT_RST;
			toggle <= 1'b0;
		end else if (ce_i) begin
			if (wr && hit_npt) begin
				npt <= lane_merge(npt, wb_dat_i, wb_sel_i) & ~16'h4800; // RQ8 RQ9
			end
			if (tx_sent_i) begin
				toggle <= ~tx_lcw_toggle_i; // RQ10
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gctl <= `AGR_GCTL_RST; // RQ14
			iac <= `AGR_IAC_RST;
		end else if (ce_i) begin
			if (wr && hit_gctl) begin
				gctl <= lane_merge(gctl, wb_dat_i, wb_sel_i);
			end
			if (wr && hit_iac) begin
				iac <= lane_merge(iac, wb_dat_i, wb_sel_i); // RQ20 RQ21
			end
		end
	end

	// Role taken only at initial resolution; later timing swaps do not reach it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			role_master <= `AGR_GSTS_ROLE_RST;
		end else if (ce_i && ms_resolve_i) begin
			role_master <= ms_resolved_master_i; // RQ17
		end
	end

	// Saturating idle error count; a read restarts it, counting an error in that cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt <= 8'h00;
		end else if (ce_i) begin
			if (rd_gsts) begin
				idle_cnt <= {7'h00, idle_err_i}; // RQ23
			end else if (idle_err_i && idle_cnt != 8'hFF) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

	// Indirect window address, written in address mode, stepped in the post-increment data modes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_addr <= 16'h0000;
		end else if (ce_i) begin
			if (win_wr && fn_addr) begin
				win_addr <= lane_merge(win_addr, wb_dat_i, wb_sel_i); // RQ22
			end else if (inc_after_wr || inc_after_rd) begin
				win_addr <= win_addr + 16'h0001; // RQ20
			end
		end
	end

	// Registered outputs towards the PHY core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			np_tx_word_o <= `AGR_NPT_RST;
			test_mode_o <= AGR_TM_NORMAL;
			ms_force_o <= 1'b0;
			ms_master_o <= 1'b0;
			adv_1000_fdx_o <= 1'b1;
			adv_1000_hdx_o <= 1'b1;
			port_single_o <= 1'b1;
			mmd_dev_o <= 5'h00;
			mmd_addr_o <= 16'h0000;
			mmd_wdata_o <= 16'h0000;
			mmd_wr_o <= 1'b0;
			mmd_rd_o <= 1'b0;
		end else if (ce_i) begin
			np_tx_word_o <= npt_word;
			test_mode_o <= next_test_mode; // RQ12
			ms_force_o <= gctl[`AGR_GCTL_MANUAL];
			ms_master_o <= gctl[`AGR_GCTL_MANUAL] & gctl[`AGR_GCTL_MASTER]; // RQ13
			adv_1000_fdx_o <= gctl[`AGR_GCTL_FDX]; // RQ14
			adv_1000_hdx_o <= gctl[`AGR_GCTL_HDX];
			port_single_o <= gctl[`AGR_GCTL_PORT];
			mmd_dev_o <= iac[`AGR_IAC_DEV_HI:0];
			mmd_addr_o <= win_addr;
			mmd_wdata_o <= win_wr ? lane_merge(16'h0000, wb_dat_i, wb_sel_i) : mmd_wdata_o;
			mmd_wr_o <= win_wr & ~fn_addr; // RQ22
			mmd_rd_o <= win_rd & ~fn_addr;
		end
	end

	// Latched flags; a read acts at the edge that takes the request, the same edge that raises ack
	agr_latch #(.LATCH_HIGH(1'b1)) u_pdf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.live_i(pd_fault_i),
		.rd_i(rd_exp),
		.q_o(flag_pdf)
	); // RQ4

	agr_latch #(.LATCH_HIGH(1'b0)) u_prx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.live_i(page_rcvd_i),
		.rd_i(rd_exp),
		.q_o(flag_prx)
	); // RQ5

	agr_latch #(.LATCH_HIGH(1'b1)) u_msf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.live_i(ms_fault_i),
		.rd_i(rd_gsts),
		.q_o(flag_msf)
	); // RQ16

	AST_PBA_RO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
		(wr && hit_pba && !rx_page_i) |=> $stable(pba))
		else $error("partner base changed by a write");

	AST_PDF_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
		(ce_i && pd_fault_i) |=> flag_pdf)
		else $error("parallel detection fault not latched");

	AST_PRX_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
		(ce_i && !page_rcvd_i) |=> !flag_prx)
		else $error("page received flag not latched low");

	AST_EXP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
		rd_exp |=> (wb_ack_o && wb_dat_o[15:5] == 11'h000 && wb_dat_o[2]))
		else $error("expansion read has bad fixed bits");

	AST_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
		(ce_i && tx_sent_i) |=> (toggle == !$past(tx_lcw_toggle_i)))
		else $error("toggle not inverse of last codeword");

	AST_MS_FORCE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
		ms_master_o |-> $past(gctl[`AGR_GCTL_MANUAL]))
		else $error("forced master without manual enable");

	AST_ROLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
		!ms_resolve_i |=> $stable(role_master))
		else $error("resolved role changed without resolution");

	AST_IDLE_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // RQ23
		(rd_gsts && !idle_err_i) |=> (idle_cnt == 8'h00))
		else $error("idle error count not cleared by read");

	AST_WIN_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
		(win_wr && fn_addr && wb_sel_i[1:0] == 2'h3) |=> (win_addr == $past(wb_dat_i[15:0])))
		else $error("window address not taken in address mode");

	AST_TEST_RSVD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
		(ce_i && gctl[15:13] > 3'h4) |=> test_mode_o == AGR_TM_NORMAL)
		else $error("reserved test code not treated as normal");

	// Latched flags, read-only bits, captures and window accesses
	AST_PDF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
		(flag_pdf && !rd_exp) |=> flag_pdf)
		else $error("parallel detection fault dropped before read");

	AST_NPT_RO_BITS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
		(wr && hit_npt) |=> (npt[`AGR_NPT_RSVD] == 1'b0 && npt[`AGR_NPT_TOGGLE] == 1'b0))
		else $error("read-only next page bits taken from a write");

	AST_NPR_MIRROR: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
		(ce_i && rx_page_i && rx_next_page_i) |=> (npr == $past(rx_word_i)))
		else $error("received next page not mirrored");

	AST_MSF_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
		(ce_i && ms_fault_i) |=> flag_msf)
		else $error("role configuration fault not latched");

	AST_ROLE_TAKE: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
		(ce_i && ms_resolve_i) |=> (role_master == $past(ms_resolved_master_i)))
		else $error("resolved role not captured");

	AST_GSTS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
		rd_gsts |=> (wb_ack_o && wb_dat_o[9:8] == 2'h0))
		else $error("gigabit status reserved bits not zero");

	AST_WIN_INC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
		(inc_after_wr || inc_after_rd) |=> (win_addr == $past(win_addr) + 16'h0001))
		else $error("window address not stepped after data access");

	AST_MMD_RD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
		(win_rd && !fn_addr) |=> (mmd_rd_o && mmd_addr_o == $past(win_addr)))
		else $error("indirect read pulse or address wrong");

	AST_PRX_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i) // RQ23
		(rd_exp && page_rcvd_i) |=> flag_prx)
		else $error("page received flag not reloaded by read");

endmodule

`default_nettype wire

// ### sim/agr_mmd_model.sv
// Model of the indirect register space that sits behind the window.
// Assumes rdata_o is taken combinationally during the access cycle.
`timescale 1ns/10ps
`default_nettype none

module agr_mmd_model (
	input wire logic clk_i, // Clock
	input wire logic [4:0] dev_i, // Target device address
	input wire logic [15:0] addr_i, // Register address
	input wire logic [15:0] wdata_i, // Write data
	input wire logic wr_i, // Write pulse
	output logic [15:0] rdata_o // Read data
);
	logic [15:0] mem [16];
	// Seeded so unwritten places still give known data
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'h5A00 + 16'(i);
		end
	end
	// Device address folded in so a wrong device shows up
	assign rdata_o = mem[addr_i[3:0]] ^ {11'h000, dev_i};
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem[addr_i[3:0]] <= wdata_i ^ {11'h000, dev_i};
		end
	end
endmodule

`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the register bank and the indirect space model.
// Assumes a classic Wishbone slave that acks each request once.
`timescale 1ns/10ps
`default_nettype none

module tb import agr_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, rx_np = 1'b0;
	logic pr = 1'b0, an = 1'b0, tog = 1'b0, msm = 1'b0, ier = 1'b0, ce = 1'b1;
	logic frc, mst, af, ah, ps, mwr, mrp;
	logic [4:0] ev = 5'h00, mdev;
	logic [3:0] st = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [15:0] dw = 16'h0000, rxw = 16'h0000, mrd, npw, madr, mwd;
	logic [31:0] dr, rd;
	logic [1:0] pw;
	agr_tm_e tm;
	int n_mismatch = 0, check_count = 0;
	logic [7:0] rst_a [8] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h34, 8'h3C};
	logic [15:0] rst_v [8] = '{16'h0, 16'h0004, 16'h2001, 16'h0, 16'h0700, 16'h4000, 16'h0, 16'h0};

	always #20 clk_i = ~clk_i;

	agr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i({16'h0, dw}), .wb_dat_o(dr),
		.wb_ack_o(ack), .rx_page_i(ev[0]), .rx_next_page_i(rx_np), .rx_word_i(rxw),
		.page_rcvd_i(pr), .pd_fault_i(ev[1]), .lp_an_able_i(an), .tx_sent_i(ev[2]),
		.tx_lcw_toggle_i(tog), .ms_fault_i(ev[3]), .ms_resolve_i(ev[4]),
		.ms_resolved_master_i(msm), .local_rx_ok_i(st[3]), .remote_rx_ok_i(st[2]),
		.lp_1000_fdx_i(st[1]), .lp_1000_hdx_i(st[0]), .idle_err_i(ier), .mmd_rdata_i(mrd),
		.np_tx_word_o(npw), .test_mode_o(tm), .ms_force_o(frc), .ms_master_o(mst),
		.adv_1000_fdx_o(af), .adv_1000_hdx_o(ah), .port_single_o(ps), .mmd_dev_o(mdev),
		.mmd_addr_o(madr), .mmd_wdata_o(mwd), .mmd_wr_o(mwr), .mmd_rd_o(mrp));

	agr_mmd_model mdl_u (.clk_i(clk_i), .dev_i(mdev), .addr_i(madr), .wdata_i(mwd),
		.wr_i(mwr), .rdata_o(mrd));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			n_mismatch++;
			final_report();
		end else begin
			rd = dr;
			pw = {mwr, mrp};
			cyc <= 1'b0;
		end
	endtask

	task automatic pul(input logic [4:0] m);
		@(posedge clk_i);
		ev <= m;
		@(posedge clk_i);
		ev <= 5'h00;
	endtask

	function automatic logic [15:0] exp_npt(input logic [15:0] w, input logic t);
		return (w & 16'hB7FF) | {4'h0, ~t, 11'h000};
	endfunction

	initial begin
		logic [15:0] w, a;
		logic [4:0] dv;
		logic t;
		int k;
		void'($urandom(82));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, rst_a[i], 16'h0);
			chk("reset value", rd, {16'h0, rst_v[i]});
		end
		chk("tx word reset", npw, 32'h2001);
		w = 16'($urandom);
		rxw <= w;
		pul(5'h01);
		wb(1'b1, 8'h14, ~w);
		wb(1'b0, 8'h14, 16'h0);
		chk("partner base", rd, {16'h0, w});
		a = 16'($urandom);
		rxw <= a;
		rx_np <= 1'b1;
		pul(5'h01);
		wb(1'b0, 8'h20, 16'h0);
		chk("partner next page", rd, {16'h0, a});
		// A page while the clock enable is low must be lost
		ce <= 1'b0;
		rxw <= ~a;
		pul(5'h01);
		ce <= 1'b1;
		wb(1'b0, 8'h20, 16'h0);
		chk("frozen page", rd, {16'h0, a});
		an <= 1'b1;
		pr <= 1'b1;
		pul(5'h02);
		wb(1'b0, 8'h18, 16'h0);
		chk("expansion", rd, {27'h0, 1'b1, w[15], 3'b101});
		wb(1'b0, 8'h18, 16'h0);
		chk("expansion reread", rd, {27'h0, 1'b0, w[15], 3'b111});
		@(posedge clk_i);
		pr <= 1'b0;
		@(posedge clk_i);
		pr <= 1'b1;
		wb(1'b0, 8'h18, 16'h0);
		chk("page dropout", rd, {27'h0, 1'b0, w[15], 3'b101});
		for (int i = 0; i < 4; i++) begin
			w = 16'($urandom);
			t = 1'($urandom);
			tog <= t;
			wb(1'b1, 8'h1C, w);
			pul(5'h04);
			wb(1'b0, 8'h1C, 16'h0);
			chk("next page tx", rd, {16'h0, exp_npt(w, t)});
			chk("tx word", npw, {16'h0, exp_npt(w, t)});
		end
		for (int i = 0; i < 8; i++) begin
			w = {3'(i), 1'(i), 1'($urandom), 11'($urandom)};
			// No media sense in this bank, so tests are picked directly
			wb(1'b1, 8'h24, w);
			wb(1'b0, 8'h24, 16'h0);
			chk("gigabit control", rd, {16'h0, w});
			chk("test mode", tm, (i < 5) ? i : 0);
			chk("role", {frc, mst}, {w[12], w[12] & w[11]});
			chk("advertise", {af, ah, ps}, {w[9], w[8], w[10]});
		end
		st <= 4'($urandom);
		k = $urandom_range(5, 1);
		pul(5'h10);
		pul(5'h08);
		ier <= 1'b1;
		repeat (k) @(posedge clk_i);
		ier <= 1'b0;
		wb(1'b0, 8'h28, 16'h0);
		chk("gigabit status", rd, {16'h0, 2'b10, st, 2'b00, 8'(k)});
		wb(1'b0, 8'h28, 16'h0);
		chk("status reread", rd, {16'h0, 2'b00, st, 10'h000});
		msm <= 1'b1;
		ier <= 1'b1;
		repeat (300) @(posedge clk_i);
		ier <= 1'b0;
		wb(1'b0, 8'h28, 16'h0);
		chk("role kept", rd, {16'h0, 2'b00, st, 10'h0FF});
		dv = 5'($urandom);
		for (int f = 1; f < 4; f++) begin
			a = 16'(4 * f);
			w = 16'($urandom);
			wb(1'b1, 8'h34, {11'h0, dv});
			wb(1'b1, 8'h38, a);
			wb(1'b1, 8'h34, {2'(f), 9'h0, dv});
			wb(1'b1, 8'h38, w);
			chk("window write pulse", pw, 2'b10);
			chk("window write data", mwd, w);
			wb(1'b0, 8'h38, 16'h0);
			chk("window data", rd, {16'h0, (f == 1) ? w : (16'h5A01 + a) ^ {11'h0, dv}});
			chk("window read pulse", pw, 2'b01);
			chk("target device", mdev, dv);
			wb(1'b1, 8'h34, {11'h0, dv});
			wb(1'b0, 8'h38, 16'h0);
			chk("window address", rd, 32'(a) + ((f > 1) ? 1 : 0) + ((f == 2) ? 1 : 0));
			chk("address mode pulse", pw, 2'b00);
		end
		final_report();
	end
endmodule

`default_nettype wire
